// File: reader_command_irq_fifo_ctrl.sv
// Behaviour
// - command byte: mode bits 11, six code bits MSB first, run on last falling edge
// - any interrupt event sets its status bit; an unmasked event also raises the request output
// - reading interrupt status clears all bits and drops the request; bits accumulate
// - masked source keeps its status bit but cannot raise the request
// - clear after status read is timed by the core clock
// - oscillator off in target mode: clear waits for next serial clock rise
// - 32-byte fifo; receive overflow sets a flag and drops the byte
// - transmit: water-level event when bytes left fall below transmit level
// - receive: water-level event when bytes held exceed receive level
// - config field picks one of two levels each for receive and transmit
// - fifo status shows count of unread bytes
// - code 01 restores defaults, code 02 stops activity and empties fifo
// - set default reloads every register, drops calibration, works in every mode
// - clear also resets collision and interrupt state; host sends it before transmits
// - codes 04 and 05 start transmit with and without crc
// - codes 06 and 07 send short frames, only in type A mode
// - codes 08 to 0a send nfc frames after collision avoidance
// - code 10 masks receive, code 11 unmasks and beats the mask timer
// - codes 12 to 15 convert, measure, squelch and undo squelch
// - codes 16 to 18 adjust regulators, calibrate modulation, tune antenna
// - codes 19, 1a, 1c check resonance, clear rssi, enter transparent mode
// - serial input sampled on falling clock, bytes MSB first, reset while select low
`timescale 1ns/1ps
`default_nettype none
module reader_command_irq_fifo_ctrl (
  input  wire logic       core_clk,              // 200 MHz core clock
  input  wire logic       rst,                   // sync reset, active high
  input  wire logic       serial_select_line,    // serial enable, low holds reset
  input  wire logic       serial_clk,            // serial clock pin
  input  wire logic       serial_in_line,        // serial data pin
  input  wire logic [5:0] reg_addr,              // register address
  input  wire logic [7:0] reg_wdata,             // register write data
  input  wire logic       reg_wr,                // write strobe
  input  wire logic       reg_rd,                // read strobe
  output logic      [7:0] reg_rdata,             // read data, cycle after strobe
  input  wire logic [6:0] irq_event,             // event pulses from other blocks
  input  wire logic       osc_on,                // oscillator running
  input  wire logic       target_init_mode,      // initial target mode
  input  wire logic       iso_a_mode,            // type A protocol selected
  input  wire logic       tx_active,             // transmission in progress
  input  wire logic       rx_active,             // reception in progress
  input  wire logic       rx_push,               // received byte strobe
  input  wire logic [7:0] rx_byte,               // received byte
  input  wire logic       tx_pop,                // framer takes next byte
  input  wire logic       rx_mask_timer,         // mask timer requests masking
  output logic            interrupt_request_out, // interrupt request
  output logic            cmd_valid,             // accepted command pulse
  output logic      [5:0] cmd_code,              // accepted command code
  output logic            default_pulse,         // set default issued
  output logic            clear_pulse,           // clear issued
  output logic            rx_masked,             // receive data ignored
  output logic      [7:0] tx_byte,               // byte to framer
  output logic            tx_byte_valid          // tx_byte fresh
);
  // pin synchronisers
  logic sel_ff1, sel_s;
  logic clk_ff1, clk_s, clk_d;
  logic din_ff1, din_s;
  logic sclk_fall, sclk_rise;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sel_ff1 <= 1'b0;
      sel_s   <= 1'b0;
      clk_ff1 <= 1'b0;
      clk_s   <= 1'b0;
      clk_d   <= 1'b0;
      din_ff1 <= 1'b0;
      din_s   <= 1'b0;
    end else begin
      sel_ff1 <= serial_select_line;
      sel_s   <= sel_ff1;
      clk_ff1 <= serial_clk;
      clk_s   <= clk_ff1;
      clk_d   <= clk_s;
      din_ff1 <= serial_in_line;
      din_s   <= din_ff1;
    end
  end

  assign sclk_fall = clk_d && !clk_s;
  assign sclk_rise = !clk_d && clk_s;
  // first byte capture
  logic [6:0] shift;
  logic [2:0] bit_cnt;
  logic       first_byte;
  logic [7:0] cmd_byte;
  logic [5:0] code_in;
  logic       cmd_fire;
  logic       accepted;
  logic       do_default;
  logic       do_clear;
  always_ff @(posedge core_clk) begin
    if (rst || !sel_s) begin
      shift      <= 7'h00;
      bit_cnt    <= 3'h0;
      first_byte <= 1'b1;
    end else if (sclk_fall && first_byte) begin
      shift   <= cmd_byte[6:0];
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == reader_pkg::LAST_BIT) begin
        first_byte <= 1'b0;
      end
    end
  end

  assign cmd_byte = {shift, din_s};
  assign code_in  = cmd_byte[5:0];
  assign cmd_fire = sel_s && first_byte && sclk_fall && bit_cnt == reader_pkg::LAST_BIT
                    && cmd_byte[7:6] == reader_pkg::MODE_CMD;
  function automatic logic code_known(input logic [5:0] c, input logic a_mode);
    unique case (c)
      reader_pkg::CMD_SET_DEFAULT, reader_pkg::CMD_CLEAR: code_known = 1'b1;
      reader_pkg::CMD_TX_CRC, reader_pkg::CMD_TX_NOCRC: code_known = 1'b1;
      reader_pkg::CMD_TX_REQA, reader_pkg::CMD_TX_WUPA: code_known = a_mode;
      reader_pkg::CMD_NFC_INIT, reader_pkg::CMD_NFC_RESP,
      reader_pkg::CMD_NFC_RESP0: code_known = 1'b1;
      reader_pkg::CMD_RX_MASK, reader_pkg::CMD_RX_UNMASK: code_known = 1'b1;
      reader_pkg::CMD_AD_CONV, reader_pkg::CMD_MEAS_RF, reader_pkg::CMD_SQUELCH,
      reader_pkg::CMD_CLR_SQUELCH: code_known = 1'b1;
      reader_pkg::CMD_ADJ_REG, reader_pkg::CMD_CAL_MOD,
      reader_pkg::CMD_CAL_ANT: code_known = 1'b1;
      reader_pkg::CMD_CHK_ANT, reader_pkg::CMD_CLR_RSSI,
      reader_pkg::CMD_TRANSPARENT: code_known = 1'b1;
      default: code_known = 1'b0;
    endcase
  endfunction
  assign accepted   = cmd_fire && code_known(code_in, iso_a_mode);
  assign do_default = accepted && code_in == reader_pkg::CMD_SET_DEFAULT;
  assign do_clear   = accepted && code_in == reader_pkg::CMD_CLEAR;
  // dispatch to sequencers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmd_valid     <= 1'b0;
      cmd_code      <= 6'h00;
      default_pulse <= 1'b0;
      clear_pulse   <= 1'b0;
    end else begin
      cmd_valid     <= accepted;
      default_pulse <= do_default;
      clear_pulse   <= do_clear;
      if (accepted) begin
        cmd_code <= code_in;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || do_default) begin
      rx_masked <= 1'b0;
    end else if (accepted && code_in == reader_pkg::CMD_RX_UNMASK) begin
      rx_masked <= 1'b0;
    end else if ((accepted && code_in == reader_pkg::CMD_RX_MASK) || rx_mask_timer) begin
      rx_masked <= 1'b1;
    end
  end

  // register file
  logic [7:0] irq_mask;
  logic [1:0] cfg;
  logic       wr_mask, wr_fifo, rd_fifo, rd_irq;
  assign wr_mask = reg_wr && reg_addr == reader_pkg::ADDR_MASK;
  assign wr_fifo = reg_wr && reg_addr == reader_pkg::ADDR_FIFO;
  assign rd_fifo = reg_rd && reg_addr == reader_pkg::ADDR_FIFO;
  assign rd_irq  = reg_rd && reg_addr == reader_pkg::ADDR_IRQ;
  always_ff @(posedge core_clk) begin
    if (rst || do_default) begin
      irq_mask <= reader_pkg::MASK_RST;
      cfg      <= reader_pkg::CFG_RST;
    end else if (reg_wr) begin
      if (reg_addr == reader_pkg::ADDR_MASK) begin
        irq_mask <= reg_wdata;
      end
      if (reg_addr == reader_pkg::ADDR_CFG) begin
        cfg <= reg_wdata[1:0];
      end
    end
  end

  // fifo
  logic [7:0] fifo_head;
  logic [5:0] fifo_count;
  logic [5:0] count_d;
  logic       fifo_full, fifo_empty, fifo_ovf, fifo_flush;
  logic       rx_wr;
  logic [5:0] rx_wl, tx_wl;
  logic       tx_wl_evt, rx_wl_evt;
  assign fifo_flush = do_clear || do_default;
  assign rx_wr      = rx_push && rx_active;
  reader_fifo i_reader_fifo (
    .clk       (core_clk),
    .rst       (rst),
    .flush     (fifo_flush),
    .push      (rx_wr || wr_fifo),
    .push_data (rx_wr ? rx_byte : reg_wdata),
    .pop       (rd_fifo || tx_pop),
    .head      (fifo_head),
    .count     (fifo_count),
    .full      (fifo_full),
    .empty     (fifo_empty)
  );
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fifo_ovf <= 1'b0;
    end else if (rx_wr && fifo_full) begin
      fifo_ovf <= 1'b1;
    end else if (fifo_flush) begin
      fifo_ovf <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_d <= 6'h00;
    end else begin
      count_d <= fifo_count;
    end
  end

  assign rx_wl = cfg[reader_pkg::CFG_RXWL_BIT] ? reader_pkg::RX_WL1 : reader_pkg::RX_WL0;
  assign tx_wl = cfg[reader_pkg::CFG_TXWL_BIT] ? reader_pkg::TX_WL1 : reader_pkg::TX_WL0;
  assign tx_wl_evt = tx_active && fifo_count < tx_wl && count_d >= tx_wl;
  assign rx_wl_evt = rx_active && fifo_count > rx_wl && count_d <= rx_wl;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_byte       <= 8'h00;
      tx_byte_valid <= 1'b0;
    end else begin
      tx_byte_valid <= tx_pop && !fifo_empty;
      if (tx_pop && !fifo_empty) begin
        tx_byte <= fifo_head;
      end
    end
  end

  // interrupt status and clear timing
  reader_pkg::irq_clr_state_t clr_state;
  logic [7:0] irq_status;
  logic [7:0] irq_ev;
  logic [7:0] next_irq_status;
  logic       irq_clr;
  logic       wait_sclk;
  assign irq_ev    = {irq_event, tx_wl_evt || rx_wl_evt};
  assign wait_sclk = rd_irq && target_init_mode && !osc_on;
  assign irq_clr   = (rd_irq && !wait_sclk)
                     || (clr_state == reader_pkg::CLR_WAIT_SCLK && sclk_rise)
                     || do_clear || do_default;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      clr_state <= reader_pkg::CLR_IDLE;
    end else begin
      unique case (clr_state)
        reader_pkg::CLR_IDLE: begin
          if (wait_sclk) begin
            clr_state <= reader_pkg::CLR_WAIT_SCLK;
          end
        end
        reader_pkg::CLR_WAIT_SCLK: begin
          if (sclk_rise || do_clear || do_default || (rd_irq && !wait_sclk)) begin
            clr_state <= reader_pkg::CLR_IDLE;
          end
        end
        default: clr_state <= reader_pkg::CLR_IDLE;
      endcase
    end
  end

  // new events win over a clear in the same cycle
  assign next_irq_status = (irq_clr ? reader_pkg::IRQ_RST : irq_status) | irq_ev;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_status            <= reader_pkg::IRQ_RST;
      interrupt_request_out <= 1'b0;
    end else begin
      irq_status            <= next_irq_status;
      interrupt_request_out <= |(next_irq_status & ~irq_mask);
    end
  end

  // read data path
  always_ff @(posedge core_clk) begin
    if (rst || !reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (reg_addr)
        reader_pkg::ADDR_IRQ:   reg_rdata <= irq_status;
        reader_pkg::ADDR_MASK:  reg_rdata <= irq_mask;
        reader_pkg::ADDR_CFG:   reg_rdata <= {6'h00, cfg};
        reader_pkg::ADDR_FSTAT: reg_rdata <= {1'b0, fifo_ovf, fifo_count};
        reader_pkg::ADDR_FIFO:  reg_rdata <= fifo_empty ? 8'h00 : fifo_head;
        default:                reg_rdata <= 8'h00;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [7:0] ev_masked;
  logic [7:0] ev_open;
  assign ev_masked = irq_ev & irq_mask;
  assign ev_open   = irq_ev & ~irq_mask;
  sequence s_target_read;
    rd_irq && target_init_mode && !osc_on && irq_ev == 8'h00;
  endsequence
  sequence s_armed;
    clr_state == reader_pkg::CLR_WAIT_SCLK;
  endsequence
  sequence s_sclk_edge;
    sclk_rise && irq_ev == 8'h00 && !cmd_fire;
  endsequence

  a_irq_raise: assert property (
    (|ev_open && !wr_mask) |=> interrupt_request_out && |(irq_status & $past(ev_open)))
    else $error("unmasked event did not raise request");
  a_irq_read_clear: assert property (
    (rd_irq && !wait_sclk && irq_ev == 8'h00) |=> irq_status == 8'h00 && !interrupt_request_out)
    else $error("status read did not clear");
  a_irq_masked_set: assert property (
    (|ev_masked && irq_ev == ev_masked && (irq_status & ~irq_mask) == 8'h00 && !wr_mask)
    |=> !interrupt_request_out && (irq_status & $past(ev_masked)) == $past(ev_masked))
    else $error("masked event mishandled");
  a_irq_sclk_wait: assert property (
    s_armed ##0 s_sclk_edge |=> irq_status == 8'h00)
    else $error("target mode clear not on serial clock rise");
  a_irq_hold_wait: assert property (
    s_target_read |=> irq_status == $past(irq_status) || irq_ev != 8'h00 || cmd_fire)
    else $error("status cleared before serial clock rise");
  a_cmd_decode: assert property (
    accepted |=> cmd_valid && cmd_code == $past(code_in))
    else $error("command not dispatched");
  a_cmd_unknown: assert property (
    (cmd_fire && !accepted) |=> !cmd_valid && $stable(cmd_code))
    else $error("unknown command acted on");
  a_fifo_overflow: assert property (
    (rx_wr && fifo_full && !fifo_flush) |=> fifo_ovf
    && fifo_count == 6'h20 - 6'($past(rd_fifo || tx_pop)))
    else $error("overflow not flagged");
  a_clear_flush: assert property (
    do_clear |=> fifo_count == 6'h00 && fifo_ovf == $past(rx_wr && fifo_full) && clear_pulse)
    else $error("clear did not empty fifo");
  a_default_regs: assert property (
    (do_default && !rx_wr) |=> irq_mask == reader_pkg::MASK_RST && cfg == reader_pkg::CFG_RST
    && !rx_masked && fifo_count == 6'h00)
    else $error("set default left state");
  a_wl_tx_irq: assert property (
    tx_wl_evt |=> irq_status[reader_pkg::IRQ_WL_BIT])
    else $error("transmit water level missed");
  a_wl_rx_irq: assert property (
    (rx_active && fifo_count > rx_wl && count_d <= rx_wl) |=> irq_status[reader_pkg::IRQ_WL_BIT])
    else $error("receive water level missed");
  a_fstat_count: assert property (
    (reg_rd && reg_addr == reader_pkg::ADDR_FSTAT) |=> reg_rdata[5:0] == $past(fifo_count))
    else $error("fifo count misreported");
  a_rx_unmask: assert property (
    (accepted && code_in == reader_pkg::CMD_RX_UNMASK) |=> !rx_masked)
    else $error("unmask lost to mask timer");
endmodule // reader_command_irq_fifo_ctrl
`default_nettype wire

// File: reader_pkg.sv
`default_nettype none
package reader_pkg;
  // register offsets
  localparam logic [5:0] ADDR_IRQ   = 6'h00;
  localparam logic [5:0] ADDR_MASK  = 6'h01;
  localparam logic [5:0] ADDR_CFG   = 6'h02;
  localparam logic [5:0] ADDR_FSTAT = 6'h03;
  localparam logic [5:0] ADDR_FIFO  = 6'h04;
  // reset values
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [1:0] CFG_RST  = 2'h0;
  localparam logic [7:0] IRQ_RST  = 8'h00;
  // field positions
  localparam int CFG_RXWL_BIT  = 0;
  localparam int CFG_TXWL_BIT  = 1;
  localparam int FSTAT_OVF_BIT = 6;
  localparam int IRQ_WL_BIT    = 0;
  // fifo geometry and water levels
  localparam int FIFO_DEPTH = 32;
  localparam int PTR_W      = 5;
  localparam int CNT_W      = 6;
  localparam logic [5:0] RX_WL0 = 6'h10;
  localparam logic [5:0] RX_WL1 = 6'h18;
  localparam logic [5:0] TX_WL0 = 6'h10;
  localparam logic [5:0] TX_WL1 = 6'h08;
  // serial framing
  localparam logic [1:0] MODE_CMD = 2'h3;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // direct command codes
  localparam logic [5:0] CMD_SET_DEFAULT = 6'h01;
  localparam logic [5:0] CMD_CLEAR       = 6'h02;
  localparam logic [5:0] CMD_TX_CRC      = 6'h04;
  localparam logic [5:0] CMD_TX_NOCRC    = 6'h05;
  localparam logic [5:0] CMD_TX_REQA     = 6'h06;
  localparam logic [5:0] CMD_TX_WUPA     = 6'h07;
  localparam logic [5:0] CMD_NFC_INIT    = 6'h08;
  localparam logic [5:0] CMD_NFC_RESP    = 6'h09;
  localparam logic [5:0] CMD_NFC_RESP0   = 6'h0a;
  localparam logic [5:0] CMD_RX_MASK     = 6'h10;
  localparam logic [5:0] CMD_RX_UNMASK   = 6'h11;
  localparam logic [5:0] CMD_AD_CONV     = 6'h12;
  localparam logic [5:0] CMD_MEAS_RF     = 6'h13;
  localparam logic [5:0] CMD_SQUELCH     = 6'h14;
  localparam logic [5:0] CMD_CLR_SQUELCH = 6'h15;
  localparam logic [5:0] CMD_ADJ_REG     = 6'h16;
  localparam logic [5:0] CMD_CAL_MOD     = 6'h17;
  localparam logic [5:0] CMD_CAL_ANT     = 6'h18;
  localparam logic [5:0] CMD_CHK_ANT     = 6'h19;
  localparam logic [5:0] CMD_CLR_RSSI    = 6'h1a;
  localparam logic [5:0] CMD_TRANSPARENT = 6'h1c;
  typedef enum logic [1:0] {
    CLR_IDLE      = 2'b01,
    CLR_WAIT_SCLK = 2'b10
  } irq_clr_state_t;
endpackage
`default_nettype wire

// File: reader_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module reader_fifo (
  input  wire logic       clk,       // core clock
  input  wire logic       rst,       // sync reset
  input  wire logic       flush,     // empty the fifo
  input  wire logic       push,      // write request
  input  wire logic [7:0] push_data, // byte to write
  input  wire logic       pop,       // read request
  output logic      [7:0] head,      // oldest byte
  output logic      [5:0] count,     // bytes held
  output logic            full,      // no room
  output logic            empty      // nothing held
);
  logic [7:0]                    mem [reader_pkg::FIFO_DEPTH];
  logic [reader_pkg::PTR_W-1:0]  wr_ptr;
  logic [reader_pkg::PTR_W-1:0]  rd_ptr;
  logic                          push_ok;
  logic                          pop_ok;

  assign full    = (count == 6'(reader_pkg::FIFO_DEPTH));
  assign empty   = (count == 6'h00);
  assign push_ok = push && !full;
  assign pop_ok  = pop && !empty;
  assign head    = mem[rd_ptr];

  generate
    for (genvar i = 0; i < reader_pkg::FIFO_DEPTH; i++) begin : g_entry
      always_ff @(posedge clk) begin
        if (push_ok && wr_ptr == reader_pkg::PTR_W'(i)) begin
          mem[i] <= push_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push_ok) begin
        wr_ptr <= wr_ptr + 5'h01;
      end
      if (pop_ok) begin
        rd_ptr <= rd_ptr + 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst || flush) begin
      count <= 6'h00;
    end else begin
      unique case ({push_ok, pop_ok})
        2'b10:   count <= count + 6'h01;
        2'b01:   count <= count - 6'h01;
        default: count <= count;
      endcase
    end
  end
endmodule // reader_fifo
`default_nettype wire

// File: reader_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
module reader_spi_host (
  output logic sel,  // select, high enables
  output logic sclk, // serial clock, idle low
  output logic sdi   // serial data
);
  initial begin
    sel = 1'b0;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // msb first, data moves mid low phase, device samples on fall
  task automatic send(input logic [7:0] b);
    sel = 1'b1;
    #100;
    for (int i = 7; i >= 0; i--) begin
      #31 sdi = b[i];
      #31.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
    end
    #100 sdi = ~sdi;
    sel = 1'b0;
    #100;
  endtask
  // lone rising edge that lets a target mode read clear
  task automatic tick();
    #62.5 sclk = 1'b1;
    #62.5 sclk = 1'b0;
  endtask
endmodule // reader_spi_host
`default_nettype wire

// File: test_reader_command_irq_fifo_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_reader_command_irq_fifo_ctrl;
  logic       core_clk, rst, sel, sclk, sdi, reg_wr, reg_rd, irq, cmd_valid;
  logic       dflt, clr, rx_masked, tx_byte_valid, osc_on, tmode, iso_a;
  logic       tx_active, rx_active, rx_push, tx_pop, mask_tmr;
  logic [5:0] reg_addr, cmd_code;
  logic [7:0] reg_wdata, reg_rdata, tx_byte, rx_byte;
  logic [6:0] irq_event;
  int         error_cnt = 0, n_compared = 0, n_cmd = 0, n_dflt = 0, n_clr = 0, k;
  reader_spi_host h (.sel(sel), .sclk(sclk), .sdi(sdi));
  reader_command_irq_fifo_ctrl i_reader_command_irq_fifo_ctrl (
    .core_clk, .rst, .serial_select_line(sel), .serial_clk(sclk),
    .serial_in_line(sdi), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .irq_event, .osc_on, .target_init_mode(tmode), .iso_a_mode(iso_a),
    .tx_active, .rx_active, .rx_push, .rx_byte, .tx_pop, .rx_mask_timer(mask_tmr),
    .interrupt_request_out(irq), .cmd_valid, .cmd_code, .default_pulse(dflt),
    .clear_pulse(clr), .rx_masked, .tx_byte, .tx_byte_valid);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    n_cmd += int'(cmd_valid === 1'b1);
    n_dflt += int'(dflt === 1'b1);
    n_clr += int'(clr === 1'b1);
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(string nm, logic [5:0] a, logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(nm, e, reg_rdata);
  endtask
  task automatic ev(logic [6:0] b);
    @(posedge core_clk);
    irq_event <= b;
    @(posedge core_clk);
    irq_event <= 7'h00;
  endtask
  task automatic push(logic [7:0] b);
    @(posedge core_clk);
    rx_push <= 1'b1;
    rx_byte <= b;
    @(posedge core_clk);
    rx_push <= 1'b0;
  endtask
  task automatic cmd(logic [5:0] c);
    h.send({reader_pkg::MODE_CMD, c});
  endtask
  task automatic t_reset();
    rdc("mask", reader_pkg::ADDR_MASK, 8'h00);
    rdc("cfg", reader_pkg::ADDR_CFG, 8'h00);
    rdc("fstat", reader_pkg::ADDR_FSTAT, 8'h00);
    rdc("unmapped", 6'h3f, 8'h00);
  endtask
  task automatic t_irq();
    ev(7'h01);
    ev(7'h04);
    cyc(2);
    chk("request", 8'h01, {7'h00, irq});
    rdc("status", reader_pkg::ADDR_IRQ, 8'h0a);
    chk("request", 8'h00, {7'h00, irq});
    rdc("status", reader_pkg::ADDR_IRQ, 8'h00);
    wr(reader_pkg::ADDR_MASK, 8'h02);
    ev(7'h01);
    cyc(3);
    chk("request", 8'h00, {7'h00, irq});
    rdc("status", reader_pkg::ADDR_IRQ, 8'h02);
    wr(reader_pkg::ADDR_MASK, 8'h00);
  endtask
  task automatic t_target();
    @(posedge core_clk);
    tmode <= 1'b1;
    osc_on <= 1'b0;
    ev(7'h02);
    cyc(2);
    rdc("status", reader_pkg::ADDR_IRQ, 8'h04);
    cyc(2);
    chk("request", 8'h01, {7'h00, irq});
    h.tick();
    cyc(8);
    chk("request", 8'h00, {7'h00, irq});
    rdc("status", reader_pkg::ADDR_IRQ, 8'h00);
    tmode <= 1'b0;
    osc_on <= 1'b1;
  endtask
  task automatic t_cmds();
    logic [5:0] ok [19] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0a,
      6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17, 6'h18, 6'h19,
      6'h1a, 6'h1c};
    iso_a <= 1'b1;
    cmd(reader_pkg::CMD_CLEAR);
    foreach (ok[i]) begin
      k = n_cmd;
      cmd(ok[i]);
      chk("code", {2'h0, ok[i]}, {2'h0, cmd_code});
      chk("accepted", 8'h01, 8'(n_cmd - k));
    end
    cmd(6'h10);
    chk("masked", 8'h01, {7'h00, rx_masked});
    cmd(6'h11);
    chk("masked", 8'h00, {7'h00, rx_masked});
    @(posedge core_clk) mask_tmr <= 1'b1;
    cmd(6'h11);
    chk("masked", 8'h01, {7'h00, rx_masked});
    @(posedge core_clk) mask_tmr <= 1'b0;
    cmd(6'h11);
    chk("masked", 8'h00, {7'h00, rx_masked});
    iso_a <= 1'b0;
    k = n_cmd;
    cmd(6'h06);
    cmd(6'h03);
    cmd(6'h1f);
    h.send(8'h44);
    chk("refused", 8'h00, 8'(n_cmd - k));
    wr(reader_pkg::ADDR_MASK, 8'h55);
    wr(reader_pkg::ADDR_CFG, 8'h03);
    ev(7'h01);
    k = n_dflt;
    cmd(reader_pkg::CMD_SET_DEFAULT);
    chk("default", 8'h01, 8'(n_dflt - k));
    rdc("mask", reader_pkg::ADDR_MASK, 8'h00);
    rdc("cfg", reader_pkg::ADDR_CFG, 8'h00);
    rdc("status", reader_pkg::ADDR_IRQ, 8'h00);
  endtask
  task automatic t_fifo();
    for (int i = 0; i < 33; i++) wr(reader_pkg::ADDR_FIFO, 8'(i));
    rdc("fstat", reader_pkg::ADDR_FSTAT, 8'h20);
    ev(7'h01);
    k = n_clr;
    cmd(reader_pkg::CMD_CLEAR);
    chk("clear", 8'h01, 8'(n_clr - k));
    rdc("fstat", reader_pkg::ADDR_FSTAT, 8'h00);
    rdc("status", reader_pkg::ADDR_IRQ, 8'h00);
    rx_active <= 1'b1;
    for (int i = 0; i < 17; i++) push(8'h40 + 8'(i));
    cyc(2);
    rdc("status", reader_pkg::ADDR_IRQ, 8'h01);
    wr(reader_pkg::ADDR_CFG, 8'h01);
    for (int i = 17; i < 33; i++) push(8'h40 + 8'(i));
    rdc("status", reader_pkg::ADDR_IRQ, 8'h01);
    rdc("fstat", reader_pkg::ADDR_FSTAT, 8'h60);
    rdc("fifo", reader_pkg::ADDR_FIFO, 8'h40);
    rdc("fstat", reader_pkg::ADDR_FSTAT, 8'h5f);
    rx_active <= 1'b0;
    cmd(reader_pkg::CMD_CLEAR);
    wr(reader_pkg::ADDR_CFG, 8'h02);
    for (int i = 0; i < 8; i++) wr(reader_pkg::ADDR_FIFO, 8'h80 + 8'(i));
    tx_active <= 1'b1;
    tx_pop <= 1'b1;
    @(posedge core_clk);
    tx_pop <= 1'b0;
    #1 chk("txv", 8'h01, {7'h00, tx_byte_valid});
    chk("txb", 8'h80, tx_byte);
    cyc(2);
    rdc("status", reader_pkg::ADDR_IRQ, 8'h01);
    tx_active <= 1'b0;
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end
  initial begin
    rst = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd, irq_event, rx_byte} = '0;
    {tmode, iso_a, tx_active, rx_active, rx_push, tx_pop, mask_tmr} = '0;
    osc_on = 1'b1;
    cyc(20);
    rst <= 1'b0;
    cyc(4);
    t_reset();
    t_irq();
    t_target();
    t_cmds();
    t_fifo();
    summarize();
  end
endmodule // test_reader_command_irq_fifo_ctrl
`default_nettype wire
